// file: bench/tb_oeca_top.sv
// Self-checking testbench of the oscillator enable and clock output A block
`timescale 1ns/10ps
`default_nettype none
`include "oeca_regs.svh"

module tb_oeca_top;
	logic        core_clk;
	logic        rst_b;
	logic [15:0] addr;
	logic [7:0]  wdata;
	logic        wr;
	logic        rd;
	logic [7:0]  rdata;
	logic        fast_clk;
	logic        slow_clk;
	logic        fast_en;
	logic        slow_en;
	logic        clk_a;
	logic        clk_a_oe;
	logic [3:0]  fcnt;
	logic [4:0]  scnt;
	int          failures;
	int          n_checks;

	oeca_top u_oeca_top (
		.i_core_clk          (core_clk),
		.i_rst_b             (rst_b),
		.i_addr              (addr),
		.i_wdata             (wdata),
		.i_wr                (wr),
		.i_rd                (rd),
		.o_rdata             (rdata),
		.i_fast_osc_clk      (fast_clk),
		.i_slow_osc_clk      (slow_clk),
		.o_fast_osc_enable   (fast_en),
		.o_slow_osc_enable   (slow_en),
		.o_clock_output_a    (clk_a),
		.o_clock_output_a_oe (clk_a_oe)
	);

	// ****************************************************************
	// Clock, oscillators (fast period 16, slow period 24 cycles)
	// ****************************************************************
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		fcnt <= (fcnt == 4'h7) ? 4'h0 : fcnt + 4'h1;
		scnt <= (scnt == 5'h0B) ? 5'h00 : scnt + 5'h01;
		if (fcnt == 4'h7) fast_clk <= ~fast_clk;
		if (scnt == 5'h0B) slow_clk <= ~slow_clk;
	end

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask

	task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
		@(posedge core_clk);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge core_clk);
		wr    <= 1'b0;
	endtask

	task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
		@(posedge core_clk);
		rd   <= 1'b1;
		addr <= a;
		@(posedge core_clk);
		rd   <= 1'b0;
		#1;
		d = rdata;
	endtask

	// Cycles until the next rising edge of the output, bounded
	task automatic wait_rise(output logic [31:0] c);
		logic p;
		logic rise;
		c = 32'h0;
		p = clk_a;
		do begin
			@(posedge core_clk);
			#1;
			c++;
			rise = (clk_a === 1'b1) && (p === 1'b0);
			p = clk_a;
		end while (!rise && c < 32'd2000);
	endtask

	task automatic period(input string nm, input logic [31:0] exp);
		logic [31:0] c;
		wait_rise(c);
		wait_rise(c);
		wait_rise(c);
		chk(nm, c, exp);
	endtask

	task automatic stays_low(input string nm, input logic [7:0] cfg);
		logic [31:0] h;
		wr_reg(`OECA_CLKOUT_CTRL_OFS, cfg);
		repeat (8) @(posedge core_clk);
		h = 32'h0;
		repeat (64) begin
			@(posedge core_clk);
			#1;
			if (clk_a !== 1'b0) h++;
		end
		chk(nm, h, 32'h0);
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset;
		logic [7:0] d;
		chk("fast_en", {7'h00, fast_en}, 8'h01);
		chk("slow_en", {7'h00, slow_en}, 8'h00);
		chk("oe", {7'h00, clk_a_oe}, 8'h00);
		chk("clk_a", {7'h00, clk_a}, 8'h00);
		rd_reg(`OECA_OSC_CTRL_OFS, d);
		chk("osc rst", d, 8'h04);
		rd_reg(`OECA_CLKOUT_CTRL_OFS, d);
		chk("clkout rst", d, 8'h00);
		$display("test reset done");
	endtask

	task automatic t_regs;
		logic [7:0] d;
		wr_reg(`OECA_OSC_CTRL_OFS, 8'hFF);
		wr_reg(`OECA_CLKOUT_CTRL_OFS, 8'hFF);
		#1;
		chk("fast_en hi", {7'h00, fast_en}, 8'h01);
		chk("slow_en hi", {7'h00, slow_en}, 8'h01);
		chk("oe hi", {7'h00, clk_a_oe}, 8'h01);
		rd_reg(`OECA_OSC_CTRL_OFS, d);
		chk("osc ff", d, 8'h06);
		rd_reg(`OECA_CLKOUT_CTRL_OFS, d);
		chk("clkout ff", d, 8'h7D);
		wr_reg(`OECA_OSC_CTRL_OFS, 8'h00);
		wr_reg(`OECA_CLKOUT_CTRL_OFS, 8'h00);
		#1;
		chk("fast_en lo", {7'h00, fast_en}, 8'h00);
		chk("slow_en lo", {7'h00, slow_en}, 8'h00);
		chk("oe lo", {7'h00, clk_a_oe}, 8'h00);
		wr_reg(16'h5062, 8'hFF);
		rd_reg(16'h5062, d);
		chk("unmapped", d, 8'h00);
		rd_reg(`OECA_OSC_CTRL_OFS, d);
		chk("osc zero", d, 8'h00);
		$display("test registers done");
	endtask

	task automatic t_divide;
		wr_reg(`OECA_OSC_CTRL_OFS, 8'h06);
		for (int k = 0; k < 6; k++) begin
			wr_reg(`OECA_CLKOUT_CTRL_OFS, {1'b0, k[2:0], 4'h1});
			period("fast period", 32'd16 << k);
		end
		wr_reg(`OECA_CLKOUT_CTRL_OFS, 8'h15);
		period("slow half", 32'd48);
		wr_reg(`OECA_CLKOUT_CTRL_OFS, 8'h55);
		period("slow 32", 32'd768);
		$display("test divider done");
	endtask

	task automatic t_idle;
		stays_low("oe off", 8'h20);
		stays_low("div 6", 8'h61);
		stays_low("div 7", 8'h71);
		stays_low("src 2", 8'h09);
		stays_low("src 3", 8'h0D);
		chk("oe kept", {7'h00, clk_a_oe}, 8'h01);
		wr_reg(`OECA_OSC_CTRL_OFS, 8'h02);
		stays_low("fast off", 8'h01);
		wr_reg(`OECA_OSC_CTRL_OFS, 8'h06);
		wr_reg(`OECA_CLKOUT_CTRL_OFS, 8'h05);
		period("slow one", 32'd24);
		wr_reg(`OECA_CLKOUT_CTRL_OFS, 8'h15);
		period("slow again", 32'd48);
		wr_reg(`OECA_OSC_CTRL_OFS, 8'h04);
		stays_low("slow off", 8'h15);
		$display("test idle output done");
	endtask

	// ****************************************************************
	// Verdict and main sequence
	// ****************************************************************
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		#(8 * 60000);
		failures++;
		$display("wrong value watchdog expected done seen hang");
		close_out();
	end

	initial begin
		failures = 0;
		n_checks = 0;
		rst_b    = 1'b0;
		addr     = 16'h0000;
		wdata    = 8'h00;
		wr       = 1'b0;
		rd       = 1'b0;
		fast_clk = 1'b0;
		slow_clk = 1'b0;
		fcnt     = 4'h0;
		scnt     = 5'h00;
		repeat (6) @(posedge core_clk);
		rst_b <= 1'b1;
		#1;
		t_reset();
		t_regs();
		t_divide();
		t_idle();
		close_out();
	end
endmodule

`default_nettype wire

// file: hw/oeca_clk_div.sv
// Power-of-two divider for clock output A
`timescale 1ns/10ps
`default_nettype none

module oeca_clk_div (
	input  wire logic    i_core_clk,
	input  wire logic    i_rst_b,
	oeca_div_if.div      dv
);

	oeca_pkg::oeca_div_st_t q;
	oeca_pkg::oeca_div_st_t d;
	logic                   rise;

	// Pick the counter bit that matches the ratio
	function automatic logic div_tap(input logic [4:0] cnt, input oeca_pkg::oeca_div_t code);
		case (code)
			oeca_pkg::OECA_DIV_2:  div_tap = cnt[0];
			oeca_pkg::OECA_DIV_4:  div_tap = cnt[1];
			oeca_pkg::OECA_DIV_8:  div_tap = cnt[2];
			oeca_pkg::OECA_DIV_16: div_tap = cnt[3];
			oeca_pkg::OECA_DIV_32: div_tap = cnt[4];
			default:               div_tap = 1'h0;
		endcase
	endfunction

	assign rise = dv.src_level & ~q.src_prev;

	always_comb begin
		d          = q;
		d.src_prev = dv.src_level;
		// Hold low and restart cleanly when idle or reserved ratio
		if (!dv.enable || !oeca_pkg::oeca_div_valid(dv.code)) begin
			d.cnt = 5'h00;
			d.out = 1'h0;
		end else begin
			if (rise) begin
				d.cnt = q.cnt + 5'h01;
			end
			if (dv.code == oeca_pkg::OECA_DIV_1) begin
				d.out = dv.src_level;
			end else begin
				d.out = div_tap(d.cnt, dv.code);
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign dv.out = q.out;

endmodule

`default_nettype wire

// file: hw/oeca_div_if.sv
// Link between register block and clock output divider
`timescale 1ns/10ps
`default_nettype none

interface oeca_div_if;
	logic                src_level;
	oeca_pkg::oeca_div_t code;
	logic                enable;
	logic                out;

	modport ctrl (output src_level, output code, output enable, input out);
	modport div  (input src_level, input code, input enable, output out);
endinterface

`default_nettype wire

// file: hw/oeca_pkg.sv
// Types shared by the oscillator enable and clock output A logic
`default_nettype none

package oeca_pkg;

	// ****************************************************************
	// Field encodings
	// ****************************************************************
	typedef enum logic [1:0] {
		OECA_SRC_FAST = 2'h0,
		OECA_SRC_SLOW = 2'h1,
		OECA_SRC_RSV2 = 2'h2,
		OECA_SRC_RSV3 = 2'h3
	} oeca_src_t;

	typedef enum logic [2:0] {
		OECA_DIV_1   = 3'h0,
		OECA_DIV_2   = 3'h1,
		OECA_DIV_4   = 3'h2,
		OECA_DIV_8   = 3'h3,
		OECA_DIV_16  = 3'h4,
		OECA_DIV_32  = 3'h5,
		OECA_DIV_RS6 = 3'h6,
		OECA_DIV_RS7 = 3'h7
	} oeca_div_t;

	// ****************************************************************
	// State records
	// ****************************************************************
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic filt;
	} oeca_sync_t;

	typedef struct packed {
		logic       fast_en;
		logic       slow_en;
		oeca_div_t  div;
		oeca_src_t  src;
		logic       oe;
		logic [7:0] rdata;
		oeca_sync_t fast_sync;
		oeca_sync_t slow_sync;
		logic       clk_out;
	} oeca_top_st_t;

	typedef struct packed {
		logic       src_prev;
		logic [4:0] cnt;
		logic       out;
	} oeca_div_st_t;

	// Divider code is one of the defined ratios
	function automatic logic oeca_div_valid(input oeca_div_t code);
		oeca_div_valid = (code <= OECA_DIV_32);
	endfunction

endpackage

`default_nettype wire

// file: hw/oeca_regs.svh
// Register offsets, field positions and reset values of the oscillator/clock-out block
`ifndef OECA_REGS_SVH
`define OECA_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define OECA_OSC_CTRL_OFS    16'h5061
`define OECA_CLKOUT_CTRL_OFS 16'h5064

// ****************************************************************
// Field positions
// ****************************************************************
`define OECA_FAST_EN_BIT    2
`define OECA_SLOW_EN_BIT    1
`define OECA_DIV_MSB        6
`define OECA_DIV_LSB        4
`define OECA_SRC_MSB        3
`define OECA_SRC_LSB        2
`define OECA_OE_BIT         0

// ****************************************************************
// Reset values
// ****************************************************************
`define OECA_FAST_EN_RST    1'h1
`define OECA_SLOW_EN_RST    1'h0
`define OECA_DIV_RST        3'h0
`define OECA_SRC_RST        2'h0
`define OECA_OE_RST         1'h0

`endif

// file: hw/oeca_top.sv
// Oscillator enable register and clock output A control
//
// Summary of operation
// - Bit 2 enables fast oscillator, resets to one
// - Bit 1 enables slow oscillator, resets to zero
// - Reserved bits read zero, writes ignored
// - Bits 6..4 divide source by powers of two
// - Bits 3..2 choose source, one is slow
// - Bit 0 enables the clock output, resets off
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "oeca_regs.svh"

module oeca_top (
	input  wire logic        i_core_clk,
	input  wire logic        i_rst_b,
	input  wire logic [15:0] i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output var  logic [7:0]  o_rdata,
	input  wire logic        i_fast_osc_clk,
	input  wire logic        i_slow_osc_clk,
	output var  logic        o_fast_osc_enable,
	output var  logic        o_slow_osc_enable,
	output var  logic        o_clock_output_a,
	output var  logic        o_clock_output_a_oe
);

	// ****************************************************************
	// State and reset image
	// ****************************************************************
	localparam oeca_pkg::oeca_top_st_t ST_RST = '{
		fast_en:   `OECA_FAST_EN_RST,
		slow_en:   `OECA_SLOW_EN_RST,
		div:       oeca_pkg::oeca_div_t'(`OECA_DIV_RST),
		src:       oeca_pkg::oeca_src_t'(`OECA_SRC_RST),
		oe:        `OECA_OE_RST,
		rdata:     8'h00,
		fast_sync: '0,
		slow_sync: '0,
		clk_out:   1'h0
	};

	oeca_pkg::oeca_top_st_t q;
	oeca_pkg::oeca_top_st_t d;
	logic                   wr_osc;
	logic                   wr_fout;
	logic                   src_ok;
	logic                   src_on;

	oeca_div_if u_div_if ();

	// ****************************************************************
	// Helpers
	// ****************************************************************
	// Three-stage pin sampler; level moves once stages two and three agree
	function automatic oeca_pkg::oeca_sync_t sync_step(
		input oeca_pkg::oeca_sync_t s,
		input logic                 pin
	);
		sync_step      = s;
		sync_step.s1   = pin;
		sync_step.s2   = s.s1;
		sync_step.s3   = s.s2;
		sync_step.filt = (s.s2 == s.s3) ? s.s3 : s.filt;
	endfunction

	// Read image of a register, reserved bits zero
	function automatic logic [7:0] reg_image(
		input logic [15:0]            addr,
		input oeca_pkg::oeca_top_st_t s
	);
		reg_image = 8'h00;
		case (addr)
			`OECA_OSC_CTRL_OFS: begin
				reg_image[`OECA_FAST_EN_BIT] = s.fast_en;
				reg_image[`OECA_SLOW_EN_BIT] = s.slow_en;
			end
			`OECA_CLKOUT_CTRL_OFS: begin
				reg_image[`OECA_DIV_MSB:`OECA_DIV_LSB] = s.div;
				reg_image[`OECA_SRC_MSB:`OECA_SRC_LSB] = s.src;
				reg_image[`OECA_OE_BIT]                = s.oe;
			end
			default: begin
				reg_image = 8'h00;
			end
		endcase
	endfunction

	// ****************************************************************
	// Register decode
	// ****************************************************************
	assign wr_osc  = i_wr && (i_addr == `OECA_OSC_CTRL_OFS);
	assign wr_fout = i_wr && (i_addr == `OECA_CLKOUT_CTRL_OFS);

	// ****************************************************************
	// Source selection toward the divider
	// ****************************************************************
	// Reserved source codes leave the output idle
	assign src_ok = (q.src == oeca_pkg::OECA_SRC_FAST) || (q.src == oeca_pkg::OECA_SRC_SLOW);

	always_comb begin
		case (q.src)
			oeca_pkg::OECA_SRC_FAST: begin
				src_on             = q.fast_en;
				u_div_if.src_level = q.fast_sync.filt & q.fast_en;
			end
			oeca_pkg::OECA_SRC_SLOW: begin
				src_on             = q.slow_en;
				u_div_if.src_level = q.slow_sync.filt & q.slow_en;
			end
			default: begin
				src_on             = 1'h0;
				u_div_if.src_level = 1'h0;
			end
		endcase
	end

	assign u_div_if.code   = q.div;
	// Stopped oscillator clears the divider, output idles low
	assign u_div_if.enable = q.oe && src_ok && src_on && oeca_pkg::oeca_div_valid(q.div);

	oeca_clk_div u_clk_div (
		.i_core_clk (i_core_clk),
		.i_rst_b    (i_rst_b),
		.dv         (u_div_if.div)
	);

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		d = q;
		if (wr_osc) begin
			d.fast_en = i_wdata[`OECA_FAST_EN_BIT];
			d.slow_en = i_wdata[`OECA_SLOW_EN_BIT];
		end
		if (wr_fout) begin
			d.div = oeca_pkg::oeca_div_t'(i_wdata[`OECA_DIV_MSB:`OECA_DIV_LSB]);
			d.src = oeca_pkg::oeca_src_t'(i_wdata[`OECA_SRC_MSB:`OECA_SRC_LSB]);
			d.oe  = i_wdata[`OECA_OE_BIT];
		end
		// Read data stands only in the cycle after the strobe
		d.rdata     = i_rd ? reg_image(i_addr, q) : 8'h00;
		d.fast_sync = sync_step(q.fast_sync, i_fast_osc_clk);
		d.slow_sync = sync_step(q.slow_sync, i_slow_osc_clk);
		d.clk_out   = u_div_if.out;
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			q <= ST_RST;
		end else begin
			q <= d;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign o_rdata             = q.rdata;
	assign o_fast_osc_enable   = q.fast_en;
	assign o_slow_osc_enable   = q.slow_en;
	assign o_clock_output_a    = q.clk_out;
	assign o_clock_output_a_oe = q.oe;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rst_b);

	fast_en_write_a: assert property (
		wr_osc |=> (o_fast_osc_enable == $past(i_wdata[`OECA_FAST_EN_BIT]))
	) else $error("fast oscillator enable did not follow write");

	slow_en_write_a: assert property (
		wr_osc |=> (o_slow_osc_enable == $past(i_wdata[`OECA_SLOW_EN_BIT]))
	) else $error("slow oscillator enable did not follow write");

	osc_rsvd_read_a: assert property (
		(i_rd && i_addr == `OECA_OSC_CTRL_OFS)
		|=> (o_rdata[7:3] == 5'h00) && !o_rdata[0]
			&& (o_rdata[`OECA_FAST_EN_BIT] == $past(q.fast_en))
	) else $error("oscillator register read image wrong");

	fout_rsvd_read_a: assert property (
		(i_rd && i_addr == `OECA_CLKOUT_CTRL_OFS)
		|=> !o_rdata[7] && !o_rdata[1]
			&& (o_rdata[`OECA_DIV_MSB:`OECA_DIV_LSB] == $past(q.div))
	) else $error("clock output register read image wrong");

	div_one_pass_a: assert property (
		(q.oe && q.fast_en && q.src == oeca_pkg::OECA_SRC_FAST
			&& q.div == oeca_pkg::OECA_DIV_1)[*3]
		|-> (o_clock_output_a == $past(q.fast_sync.filt, 2))
	) else $error("divide by one output does not follow fast source");

	slow_stopped_a: assert property (
		(q.src == oeca_pkg::OECA_SRC_SLOW && !q.slow_en)[*3] |-> !o_clock_output_a
	) else $error("stopped slow oscillator still clocks the output");

	out_disabled_a: assert property (
		(!q.oe)[*3] |-> !o_clock_output_a
	) else $error("clock output active while disabled");

	rsvd_div_low_a: assert property (
		(q.div inside {oeca_pkg::OECA_DIV_RS6, oeca_pkg::OECA_DIV_RS7})[*3] |-> !o_clock_output_a
	) else $error("reserved ratio drives the clock output");

	rsvd_src_low_a: assert property (
		(!src_ok)[*3] |-> !o_clock_output_a
	) else $error("reserved source drives the clock output");

	read_idle_zero_a: assert property (
		!i_rd |=> (o_rdata == 8'h00)
	) else $error("read data present without a read strobe");

	fast_en_hold_a: assert property (
		!wr_osc |=> $stable(o_fast_osc_enable)
	) else $error("fast oscillator enable changed without a write");

	slow_en_hold_a: assert property (
		!wr_osc |=> $stable(o_slow_osc_enable)
	) else $error("slow oscillator enable changed without a write");

	clkout_write_a: assert property (
		wr_fout
		|=> (q.div == $past(i_wdata[`OECA_DIV_MSB:`OECA_DIV_LSB]))
			&& (q.src == $past(i_wdata[`OECA_SRC_MSB:`OECA_SRC_LSB]))
			&& (o_clock_output_a_oe == $past(i_wdata[`OECA_OE_BIT]))
	) else $error("clock output fields did not follow write");

	clkout_hold_a: assert property (
		!wr_fout |=> $stable(q.div) && $stable(q.src) && $stable(o_clock_output_a_oe)
	) else $error("clock output fields changed without a write");

	osc_slow_read_a: assert property (
		(i_rd && i_addr == `OECA_OSC_CTRL_OFS)
		|=> (o_rdata[`OECA_SLOW_EN_BIT] == $past(q.slow_en))
	) else $error("slow enable read back wrong");

	clkout_src_read_a: assert property (
		(i_rd && i_addr == `OECA_CLKOUT_CTRL_OFS)
		|=> (o_rdata[`OECA_SRC_MSB:`OECA_SRC_LSB] == $past(q.src))
			&& (o_rdata[`OECA_OE_BIT] == $past(q.oe))
	) else $error("source or enable read back wrong");

	unmapped_read_a: assert property (
		(i_rd && i_addr != `OECA_OSC_CTRL_OFS && i_addr != `OECA_CLKOUT_CTRL_OFS)
		|=> (o_rdata == 8'h00)
	) else $error("unmapped address read not zero");

	fast_stopped_a: assert property (
		(q.src == oeca_pkg::OECA_SRC_FAST && !q.fast_en)[*3] |-> !o_clock_output_a
	) else $error("stopped fast oscillator still clocks the output");

	slow_one_pass_a: assert property (
		(q.oe && q.slow_en && q.src == oeca_pkg::OECA_SRC_SLOW
			&& q.div == oeca_pkg::OECA_DIV_1)[*3]
		|-> (o_clock_output_a == $past(q.slow_sync.filt, 2))
	) else $error("divide by one output does not follow slow source");

	div_step_a: assert property (
		(u_div_if.enable && q.div != oeca_pkg::OECA_DIV_1 && $stable(q.div))[*4]
			##0 $changed(o_clock_output_a)
		|-> $past(u_div_if.src_level, 2) && !$past(u_div_if.src_level, 3)
	) else $error("divided output moved without a source edge");

	fast_filter_a: assert property (
		$changed(q.fast_sync.filt)
		|-> ($past(q.fast_sync.s2) == $past(q.fast_sync.s3))
	) else $error("fast sampler moved before two stages agreed");

	slow_filter_a: assert property (
		$changed(q.slow_sync.filt)
		|-> ($past(q.slow_sync.s2) == $past(q.slow_sync.s3))
	) else $error("slow sampler moved before two stages agreed");

	osc_write_c: cover property (
		wr_osc ##1 (!o_fast_osc_enable && o_slow_osc_enable)
	);

	slow_out_c: cover property (
		(q.oe && q.src == oeca_pkg::OECA_SRC_SLOW) ##1 $rose(o_clock_output_a)
	);

	div32_toggle_c: cover property (
		(q.oe && q.div == oeca_pkg::OECA_DIV_32) ##1 $rose(o_clock_output_a)
	);

	fout_read_c: cover property (
		(i_rd && i_addr == `OECA_CLKOUT_CTRL_OFS) ##1 (o_rdata != 8'h00)
	);

	slow_gate_c: cover property (
		(q.oe && q.src == oeca_pkg::OECA_SRC_SLOW && !q.slow_en) ##2 !o_clock_output_a
	);

endmodule

`default_nettype wire
